// ===== rtc_alarm_chan.sv
module rtc_alarm_chan
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic match,
  input wire logic clear,
  input wire logic halt,
  // status
  output logic flag
);

  logic match_q;
  logic pending;
  logic raw_flag;
  logic [11:0] delay_cnt;

  wire match_start = match && !match_q && enable;
  wire delay_done = pending && delay_cnt == ALARM_DELAY_CYCLES - 12'h001;

  always_ff @(posedge mclk) begin
    if (!nrst || halt) begin
      match_q <= 1'b0;
      pending <= 1'b0;
      delay_cnt <= 12'h000;
    end else begin
      match_q <= match;
      if (match_start) begin // see R1
        pending <= 1'b1;
        delay_cnt <= 12'h000;
      end else if (delay_done) begin
        pending <= 1'b0;
      end else if (pending) begin
        delay_cnt <= delay_cnt + 12'h001;
      end
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (!nrst || halt) begin
      raw_flag <= 1'b0;
    end else if (delay_done && enable) begin
      raw_flag <= 1'b1; // see R1
    end else if (clear) begin
      raw_flag <= 1'b0; // see R2
    end
  end

  assign flag = raw_flag && enable && !halt; // see R3

  flag_masked_a: assert property ( // see R3
    @(posedge mclk) disable iff (!nrst) !enable |-> !flag)
    else $error("flag visible while channel disabled");

  alarm_delay_a: assert property ( // see R1
    @(posedge mclk) disable iff (!nrst)
    delay_done && enable && !halt |=> raw_flag)
    else $error("flag not set after match delay");

  flag_hold_a: assert property ( // see R2
    @(posedge mclk) disable iff (!nrst)
    raw_flag && !clear && !halt |=> raw_flag)
    else $error("flag dropped without a clear");

endmodule

// ===== rtc_core.sv
// Behaviour
// R1 - alarm flag sets about 61us after match
// R2 - flag clears only by writing zero; the code also clears it on halt
// R3 - disabled channel flag reads zero
// R4 - interrupt pin low exactly while flag set
// R5 - seconds BCD 00-59, carry to minutes
// R6 - minutes BCD 00-59, carry to hours
// R7 - hour rollover carries to both day counters
// R8 - seconds write restarts the sub-second divider
// R9 - software writes only valid time values
// R10 - weekday steps 0 to 6 then wraps
// R11 - software avoids weekday code seven
// R12 - month day runs to month length
// R13 - month 1 to 12, carries into year
// R14 - year 00-99, divisible by four is leap
// R15 - century bit toggles on year wrap
// R16 - trim write needs bit seven zero
// R17 - second length trimmed only at 00,20,40
// R18 - trim lengthens or shortens by twice value
// R19 - trim bits five to one zero: no change
// R20 - no trim at point of trim write
// R21 - 12-hour mode: 12 midnight, 32 noon
// R22 - halt clears trim, interrupt, enables clock out
// R23 - unused bits read zero, ignore writes
// R24 - hour bit five is pm or tens-two
module rtc_core
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // crystal pin and clock output
  input wire logic xtal_in,
  output logic crystal_clock_out,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // control and status bits
  input wire logic hour_mode_24,
  input wire logic clkout_enable,
  input wire logic osc_halt_flag,
  // alarm channels
  input wire logic weekly_alarm_enable,
  input wire logic daily_alarm_enable,
  input wire logic weekly_match,
  input wire logic daily_match,
  input wire logic flag_wr,
  input wire logic [1:0] flag_wdata,
  output logic weekly_alarm_flag,
  output logic daily_alarm_flag,
  output logic irq_out_n
);

  function automatic logic [7:0] bcd_step(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_step = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = v + 8'h01;
    end
  endfunction

  logic xs1, xs2, xs3;
  logic [15:0] prescale;
  logic [7:0] seconds_count;
  logic [7:0] minutes_count;
  logic [7:0] hours_count;
  logic [2:0] weekday_code;
  logic [7:0] monthday_count;
  logic [7:0] month_count;
  logic century;
  logic [7:0] year_count;
  logic [6:0] rate_trim;
  logic trim_skip;
  logic [7:0] next_hours;
  logic [7:0] next_rdata;

  // write decode
  wire wr_sec = reg_wr && reg_addr == SECONDS_OFS;
  wire wr_min = reg_wr && reg_addr == MINUTES_OFS;
  wire wr_hour = reg_wr && reg_addr == HOURS_OFS;
  wire wr_wday = reg_wr && reg_addr == WEEKDAY_OFS;
  wire wr_mday = reg_wr && reg_addr == MONTHDAY_OFS;
  wire wr_month = reg_wr && reg_addr == MONTH_OFS;
  wire wr_year = reg_wr && reg_addr == YEAR_OFS;
  wire wr_trim = reg_wr && reg_addr == TRIM_OFS
    && !reg_wdata[TRIM_LOCK_BIT]; // see R16

  // crystal edge: xs1 feeds only xs2
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      xs3 <= 1'b0;
    end else begin
      xs1 <= xtal_in;
      xs2 <= xs1;
      xs3 <= xs2;
    end
  end

  wire xtal_tick = xs2 && !xs3;

  // second length with trim
  wire [5:0] trim_mag = rate_trim[5:0];
  wire trim_sign = rate_trim[TRIM_SIGN_BIT];
  wire at_trim_point = seconds_count == TRIM_POINT_A
    || seconds_count == TRIM_POINT_B || seconds_count == TRIM_POINT_C;
  wire trim_active = at_trim_point && !trim_skip
    && trim_mag[5:1] != 5'h00; // see R17 see R19 see R20
  wire [5:0] trim_up = trim_mag - 6'h01;
  wire [5:0] trim_dn = ~trim_mag + 6'h01;
  wire [15:0] sec_len = !trim_active ? NOMINAL_TICKS
    : trim_sign ? NOMINAL_TICKS - {9'h000, trim_dn, 1'b0}
    : NOMINAL_TICKS + {9'h000, trim_up, 1'b0}; // see R18
  wire sec_end = prescale == sec_len - 16'h0001;
  wire sec_tick = xtal_tick && sec_end && !wr_sec;

  always_ff @(posedge mclk) begin
    if (!nrst || wr_sec) begin
      prescale <= 16'h0000; // see R8
    end else if (xtal_tick) begin
      prescale <= sec_end ? 16'h0000 : prescale + 16'h0001;
    end
  end

  // a trim written at its own point waits for the next one
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      trim_skip <= 1'b0;
    end else if (wr_trim && at_trim_point) begin
      trim_skip <= 1'b1; // see R20
    end else if (sec_tick) begin
      trim_skip <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || osc_halt_flag) begin
      rate_trim <= TRIM_RST; // see R22
    end else if (wr_trim) begin
      rate_trim <= reg_wdata[6:0];
    end
  end

  // carry chain
  wire sec_wrap = sec_tick && seconds_count == MINSEC_LAST;
  wire min_wrap = sec_wrap && minutes_count == MINSEC_LAST;
  wire hour_last = hour_mode_24 ? hours_count == HOUR24_LAST
    : hours_count == {3'b001, HOUR12_ELEVEN};
  wire day_carry = min_wrap && hour_last; // see R7
  wire leap_year = year_count[4] ? (year_count[3:0] == 4'h2
    || year_count[3:0] == 4'h6) : (year_count[3:0] == 4'h0
    || year_count[3:0] == 4'h4 || year_count[3:0] == 4'h8); // see R14
  wire short_month = month_count == 8'h04 || month_count == 8'h06
    || month_count == 8'h09 || month_count == 8'h11;
  wire [7:0] mday_last = month_count == FEB
    ? (leap_year ? 8'h29 : 8'h28)
    : (short_month ? 8'h30 : 8'h31); // see R12
  wire mday_wrap = day_carry && monthday_count == mday_last;
  wire month_wrap = mday_wrap && month_count == MONTH_LAST;
  wire year_wrap = month_wrap && year_count == YEAR_LAST;

  // low five bits stepped apart from the pm bit
  wire [7:0] hour12_step = bcd_step({3'b000, hours_count[4:0]});

  // 12-hour mode keeps pm in bit five, so 11 am steps to 32
  always_comb begin
    if (hour_mode_24) begin
      next_hours = hour_last ? 8'h00 : bcd_step(hours_count); // see R24
    end else if (hours_count[4:0] == HOUR12_ELEVEN) begin
      next_hours = {2'b00, ~hours_count[PM_BIT],
        HOUR12_TWELVE}; // see R21
    end else if (hours_count[4:0] == HOUR12_TWELVE) begin
      next_hours = {2'b00, hours_count[PM_BIT], HOUR12_ONE};
    end else begin
      next_hours = {2'b00, hours_count[PM_BIT], hour12_step[4:0]};
    end
  end

  // writes win over a carry landing in the same cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      seconds_count <= SECONDS_RST;
    end else if (wr_sec) begin
      seconds_count <= reg_wdata & SECONDS_MASK; // see R23
    end else if (sec_tick) begin
      seconds_count <= sec_wrap ? 8'h00 : bcd_step(seconds_count); // see R5
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      minutes_count <= MINUTES_RST;
    end else if (wr_min) begin
      minutes_count <= reg_wdata & MINUTES_MASK;
    end else if (sec_wrap) begin
      minutes_count <= min_wrap ? 8'h00 : bcd_step(minutes_count); // see R6
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hours_count <= HOURS_RST;
    end else if (wr_hour) begin
      hours_count <= reg_wdata & HOURS_MASK;
    end else if (min_wrap) begin
      hours_count <= next_hours;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      weekday_code <= WEEKDAY_RST;
    end else if (wr_wday) begin
      weekday_code <= reg_wdata[2:0];
    end else if (day_carry) begin
      weekday_code <= weekday_code >= WEEKDAY_LAST ? 3'h0
        : weekday_code + 3'h1; // see R10
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      monthday_count <= MONTHDAY_RST;
    end else if (wr_mday) begin
      monthday_count <= reg_wdata & MONTHDAY_MASK;
    end else if (day_carry) begin
      monthday_count <= mday_wrap ? 8'h01 : bcd_step(monthday_count);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      month_count <= MONTH_RST;
      century <= 1'b0;
    end else if (wr_month) begin
      month_count <= reg_wdata & MONTH_MASK & 8'h1f;
      century <= reg_wdata[CENTURY_BIT];
    end else if (mday_wrap) begin
      month_count <= month_wrap ? 8'h01 : bcd_step(month_count); // see R13
      century <= century ^ year_wrap; // see R15
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      year_count <= YEAR_RST;
    end else if (wr_year) begin
      year_count <= reg_wdata & YEAR_MASK;
    end else if (month_wrap) begin
      year_count <= year_wrap ? 8'h00 : bcd_step(year_count); // see R14
    end
  end

  // read mux, one cycle latency
  always_comb begin
    case (reg_addr)
      SECONDS_OFS: next_rdata = seconds_count;
      MINUTES_OFS: next_rdata = minutes_count;
      HOURS_OFS: next_rdata = hours_count;
      WEEKDAY_OFS: next_rdata = {5'h00, weekday_code};
      MONTHDAY_OFS: next_rdata = monthday_count;
      MONTH_OFS: next_rdata = {century, 2'b00, month_count[4:0]};
      YEAR_OFS: next_rdata = year_count;
      TRIM_OFS: next_rdata = {1'b0, rate_trim}; // see R23
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // clock out idles high when disabled; halt forces it on
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      crystal_clock_out <= 1'b1;
    end else begin
      crystal_clock_out <= (clkout_enable || osc_halt_flag)
        ? xs2 : 1'b1; // see R22
    end
  end

  // alarm channels: index 1 weekly, 0 daily
  wire [1:0] alarm_en = {weekly_alarm_enable, daily_alarm_enable};
  wire [1:0] alarm_match = {weekly_match, daily_match};
  logic [1:0] alarm_flag;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_alarm
      rtc_alarm_chan u_chan (
        .mclk(mclk),
        .nrst(nrst),
        .enable(alarm_en[ch]),
        .match(alarm_match[ch]),
        .clear(flag_wr && !flag_wdata[ch]), // see R2
        .halt(osc_halt_flag),
        .flag(alarm_flag[ch])
      );
    end
  endgenerate

  assign weekly_alarm_flag = alarm_flag[1];
  assign daily_alarm_flag = alarm_flag[0];
  // flag and pin come from the same term so they never disagree
  assign irq_out_n = !(|alarm_flag); // see R4 see R22

  sec_wrap_a: assert property ( // see R5
    @(posedge mclk) disable iff (!nrst)
    sec_tick && seconds_count == MINSEC_LAST |=> seconds_count == 8'h00)
    else $error("seconds did not wrap to 00");

  min_carry_a: assert property ( // see R6
    @(posedge mclk) disable iff (!nrst)
    sec_wrap && !wr_min && minutes_count != MINSEC_LAST
    |=> minutes_count == bcd_step($past(minutes_count)))
    else $error("minutes did not take the carry");

  day_carry_a: assert property ( // see R7
    @(posedge mclk) disable iff (!nrst)
    min_wrap && hour_mode_24 && hours_count == HOUR24_LAST |-> day_carry)
    else $error("hour rollover gave no day carry");

  noon_step_a: assert property ( // see R21
    @(posedge mclk) disable iff (!nrst)
    min_wrap && !wr_hour && !hour_mode_24 && hours_count == 8'h11
    |=> hours_count == 8'h32)
    else $error("12-hour noon not 32");

  divider_restart_a: assert property ( // see R8
    @(posedge mclk) disable iff (!nrst) wr_sec |=> prescale == 16'h0000)
    else $error("seconds write did not restart divider");

  trim_neutral_a: assert property ( // see R19
    @(posedge mclk) disable iff (!nrst)
    trim_mag[5:1] == 5'h00 |-> sec_len == NOMINAL_TICKS)
    else $error("second length changed with neutral trim");

  weekday_wrap_a: assert property ( // see R10
    @(posedge mclk) disable iff (!nrst)
    day_carry && !wr_wday && weekday_code == WEEKDAY_LAST
    |=> weekday_code == 3'h0)
    else $error("weekday did not wrap");

  century_toggle_a: assert property ( // see R15
    @(posedge mclk) disable iff (!nrst)
    year_wrap && !wr_month |=> century != $past(century))
    else $error("century did not toggle");

  irq_match_a: assert property ( // see R4
    @(posedge mclk) disable iff (!nrst)
    irq_out_n == !(weekly_alarm_flag || daily_alarm_flag))
    else $error("interrupt pin disagrees with flags");

  halt_clear_a: assert property ( // see R22
    @(posedge mclk) disable iff (!nrst)
    osc_halt_flag |=> rate_trim == TRIM_RST && irq_out_n)
    else $error("halt left trim or interrupt active");

endmodule

// ===== rtc_core_bench.sv
module rtc_core_bench
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } rtc_row_t;

  logic mclk, nrst, xtal_in, crystal_clock_out, reg_wr;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic hour_mode_24, clkout_enable, osc_halt_flag;
  logic weekly_alarm_enable, daily_alarm_enable, weekly_match, daily_match;
  logic flag_wr, weekly_alarm_flag, daily_alarm_flag, irq_out_n, seen_low;
  logic [1:0] flag_wdata;
  int errors = 0;
  int num_checks = 0;
  // bit 7 of every write but the last set on purpose: unused places must drop it
  rtc_row_t rows [9] = '{'{4'h1, 8'hd9, 8'h59}, '{4'h2, 8'hf1, 8'h31},
    '{4'h3, 8'hfe, 8'h06}, '{4'h4, 8'hf1, 8'h31}, '{4'h5, 8'hf2, 8'h92},
    '{4'h6, 8'h99, 8'h99}, '{4'h7, 8'h87, 8'h07}, '{4'h0, 8'hd9, 8'h59},
    '{4'h9, 8'h55, 8'h00}};
  logic [7:0] rst_vals [8] = '{SECONDS_RST, MINUTES_RST, HOURS_RST,
    {5'h00, WEEKDAY_RST}, MONTHDAY_RST, MONTH_RST, YEAR_RST, 8'h00};
  // midnight of a new year in 12-hour mode, century bit flipped back
  logic [7:0] after_vals [7] = '{8'h00, 8'h00, 8'h12, 8'h00, 8'h01, 8'h01,
    8'h00};

  rtc_core rtc_core_i (.mclk(mclk), .nrst(nrst), .xtal_in(xtal_in),
    .crystal_clock_out(crystal_clock_out), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hour_mode_24(hour_mode_24), .clkout_enable(clkout_enable),
    .osc_halt_flag(osc_halt_flag), .weekly_alarm_enable(weekly_alarm_enable),
    .daily_alarm_enable(daily_alarm_enable), .weekly_match(weekly_match),
    .daily_match(daily_match), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
    .weekly_alarm_flag(weekly_alarm_flag),
    .daily_alarm_flag(daily_alarm_flag), .irq_out_n(irq_out_n));

  rtc_host_model rtc_host_model_i (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // fastest crystal the double sync can follow: one tick per two clocks
  initial begin
    xtal_in = 1'b0;
    forever @(negedge mclk) xtal_in <= ~xtal_in;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic fire_alarm();
    @(negedge mclk);
    daily_match = 1'b1;
    @(posedge mclk);
    // flag lands on the last edge of the count, one after this wait
    repeat (ALARM_DELAY_CYCLES - 12'h001) @(posedge mclk);
    @(negedge mclk);
    check1(daily_alarm_flag, 1'b0);
    @(posedge mclk);
    @(negedge mclk);
    check1(daily_alarm_flag, 1'b1);
    check1(irq_out_n, 1'b0);
    daily_match = 1'b0;
  endtask

  task automatic pulse_flags(input logic [1:0] value);
    @(negedge mclk);
    flag_wr = 1'b1;
    flag_wdata = value;
    @(negedge mclk);
    flag_wr = 1'b0;
  endtask

  initial begin
    nrst = 1'b0;
    hour_mode_24 = 1'b0;
    clkout_enable = 1'b0;
    osc_halt_flag = 1'b0;
    weekly_alarm_enable = 1'b0;
    daily_alarm_enable = 1'b0;
    weekly_match = 1'b0;
    daily_match = 1'b0;
    flag_wr = 1'b0;
    flag_wdata = 2'b00;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rtc_host_model_i.read_reg(4'(i), rd);
      check8(rd, rst_vals[i]);
    end
    check1(irq_out_n, 1'b1);
    check1(weekly_alarm_flag, 1'b0);
    check1(crystal_clock_out, 1'b1);
    $display("test reset done");

    foreach (rows[i]) begin
      rtc_host_model_i.write_reg(rows[i].addr, rows[i].wdata);
      rtc_host_model_i.read_reg(rows[i].addr, rd);
      check8(rd, rows[i].rdata);
    end
    $display("test register rows done");

    daily_alarm_enable = 1'b1;
    weekly_alarm_enable = 1'b1;
    fire_alarm();
    check1(weekly_alarm_flag, 1'b0);
    pulse_flags(2'b11);
    check1(daily_alarm_flag, 1'b1);
    daily_alarm_enable = 1'b0;
    @(negedge mclk);
    check1(daily_alarm_flag, 1'b0);
    check1(irq_out_n, 1'b1);
    daily_alarm_enable = 1'b1;
    @(negedge mclk);
    check1(daily_alarm_flag, 1'b1);
    pulse_flags(2'b10);
    check1(daily_alarm_flag, 1'b0);
    check1(irq_out_n, 1'b1);
    $display("test alarm flag done");

    fire_alarm();
    osc_halt_flag = 1'b1;
    seen_low = 1'b0;
    repeat (8) begin
      @(negedge mclk);
      if (crystal_clock_out === 1'b0)
        seen_low = 1'b1;
    end
    check1(seen_low, 1'b1);
    check1(daily_alarm_flag, 1'b0);
    check1(irq_out_n, 1'b1);
    rtc_host_model_i.read_reg(TRIM_OFS, rd);
    check8(rd, 8'h00);
    osc_halt_flag = 1'b0;
    $display("test halt done");

    // an old divider phase would tick long before the rewrite's second
    repeat (12000) @(posedge mclk);
    rtc_host_model_i.write_reg(SECONDS_OFS, 8'h59);
    repeat (65500) @(posedge mclk);
    rtc_host_model_i.read_reg(SECONDS_OFS, rd);
    check8(rd, 8'h59);
    for (int n = 0; n < 50 && rd === 8'h59; n++)
      rtc_host_model_i.read_reg(SECONDS_OFS, rd);
    check8(rd, 8'h00);
    for (int i = 1; i < 7; i++) begin
      rtc_host_model_i.read_reg(4'(i), rd);
      check8(rd, after_vals[i]);
    end
    $display("test rollover done");
    complete_run();
  end

  initial begin
    repeat (95000) @(posedge mclk);
    errors++;
    $display("watchdog expired");
    complete_run();
  end
endmodule

// ===== rtc_host_model.sv
module rtc_host_model
  import rtc_pkg::*;
(
  // clock
  input wire logic mclk,
  // register port
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // callers may hand in bytes with unused bits set; only the lock bit and weekday seven are fixed here
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    logic [7:0] sent;
    sent = data;
    // lock bit kept clear or the write would be lost
    if (addr == TRIM_OFS)
      sent[TRIM_LOCK_BIT] = 1'b0;
    // code seven would jump straight to zero on the next day carry
    if (addr == WEEKDAY_OFS && sent[2:0] == 3'h7)
      sent[2:0] = 3'h0;
    @(negedge mclk);
    reg_addr = addr;
    reg_wdata = sent;
    reg_wr = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    reg_wr = 1'b0;
    // released data must not look like the last byte
    reg_wdata = ~sent;
  endtask

  // read data is registered, so it lands one edge after the address
  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    @(negedge mclk);
    reg_addr = addr;
    @(posedge mclk);
    @(negedge mclk);
    data = reg_rdata;
  endtask
endmodule

// ===== rtc_pkg.sv
package rtc_pkg;

  // register offsets on the register port
  localparam logic [3:0] SECONDS_OFS = 4'h0;
  localparam logic [3:0] MINUTES_OFS = 4'h1;
  localparam logic [3:0] HOURS_OFS = 4'h2;
  localparam logic [3:0] WEEKDAY_OFS = 4'h3;
  localparam logic [3:0] MONTHDAY_OFS = 4'h4;
  localparam logic [3:0] MONTH_OFS = 4'h5;
  localparam logic [3:0] YEAR_OFS = 4'h6;
  localparam logic [3:0] TRIM_OFS = 4'h7;

  // implemented bits per register; the rest read zero
  localparam logic [7:0] SECONDS_MASK = 8'h7f;
  localparam logic [7:0] MINUTES_MASK = 8'h7f;
  localparam logic [7:0] HOURS_MASK = 8'h3f;
  localparam logic [7:0] WEEKDAY_MASK = 8'h07;
  localparam logic [7:0] MONTHDAY_MASK = 8'h3f;
  localparam logic [7:0] MONTH_MASK = 8'h9f;
  localparam logic [7:0] YEAR_MASK = 8'hff;
  localparam logic [7:0] TRIM_MASK = 8'h7f;

  // field positions
  localparam int CENTURY_BIT = 7;
  localparam int PM_BIT = 5;
  localparam int TRIM_SIGN_BIT = 6;
  localparam int TRIM_LOCK_BIT = 7;

  // reset values
  localparam logic [7:0] SECONDS_RST = 8'h00;
  localparam logic [7:0] MINUTES_RST = 8'h00;
  localparam logic [7:0] HOURS_RST = 8'h00;
  localparam logic [2:0] WEEKDAY_RST = 3'h0;
  localparam logic [7:0] MONTHDAY_RST = 8'h01;
  localparam logic [7:0] MONTH_RST = 8'h01;
  localparam logic [7:0] YEAR_RST = 8'h00;
  localparam logic [6:0] TRIM_RST = 7'h00;

  // counter limits and special BCD values
  localparam logic [7:0] MINSEC_LAST = 8'h59;
  localparam logic [7:0] HOUR24_LAST = 8'h23;
  localparam logic [4:0] HOUR12_ELEVEN = 5'h11;
  localparam logic [4:0] HOUR12_TWELVE = 5'h12;
  localparam logic [4:0] HOUR12_ONE = 5'h01;
  localparam logic [2:0] WEEKDAY_LAST = 3'h6;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] TRIM_POINT_A = 8'h00;
  localparam logic [7:0] TRIM_POINT_B = 8'h20;
  localparam logic [7:0] TRIM_POINT_C = 8'h40;

  // timing
  localparam logic [15:0] NOMINAL_TICKS = 16'h8000;
  localparam int MCLK_PERIOD_NS = 20;
  localparam int ALARM_DELAY_NS = 61000;
  localparam logic [11:0] ALARM_DELAY_CYCLES =
    12'(ALARM_DELAY_NS / MCLK_PERIOD_NS);

endpackage
